// ==== core/ncs_clkgen.v ====
// Edge-counting divider: toggles its output every HALF rising edges of a
// synchronised clock level. Assumes clk_in is already on ref_clk.
`timescale 1ns/1ps
`include "ncs_map.vh"

module ncs_clkgen #(
  parameter [2:0] HALF = 3'h1
) (
  input  wire ref_clk,
  input  wire rstn,
  input  wire clk_in,
  output reg  clk_out
);

  reg       clk_prev;
  reg [2:0] cnt;
  wire      rise = clk_in & ~clk_prev;

  // Count input rising edges, toggle on the last of each half period
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_prev <= 1'b0;
      cnt      <= 3'h0;
      clk_out  <= 1'b0;
    end else begin
      clk_prev <= clk_in;
      if (rise) begin
        if (cnt == HALF - 3'h1) begin
          cnt     <= 3'h0;
          clk_out <= ~clk_out;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end

endmodule // ncs_clkgen

// ==== core/ncs_map.vh ====
// Register map, field positions and reset values of the reference and
// bus clock output select block; included by every design file but the synchroniser.
`ifndef NCS_MAP_VH
`define NCS_MAP_VH

// Register indexes; byte address on the bus is four times the index
`define NCS_IDX_NETREF_SELECT      3'h1
`define NCS_IDX_PROG_CLK_OUTPUTS   3'h2
`define NCS_IDX_STATUS             3'h3
`define NCS_IDX_GENERAL_PURPOSE    3'h4

// Fields of netref_select
`define NCS_REF_OUT_ENABLE         7
`define NCS_REF_ROUTE_INPUT        6
`define NCS_DEJITTER_BYPASS        5
`define NCS_REF_INVERT             4
`define NCS_REF_SOURCE_SEL_HI      3
`define NCS_REF_SOURCE_SEL_LO      0

// Fields of programmable_clock_outputs
`define NCS_FRAMER_CLK_SOURCE_HI   7
`define NCS_FRAMER_CLK_SOURCE_LO   5
`define NCS_BUS_CLK_INPUT_INTERP   4
`define NCS_A_PAIR_OUT_ENABLE      3
`define NCS_B_PAIR_OUT_ENABLE      2
`define NCS_BUS_CLK_RATE_SEL       1
`define NCS_FRAME_WIDTH_RESERVED   0

// Reference source codes
`define NCS_REF_OSC_DIV8           4'h0
`define NCS_REF_OSC                4'h1

// Framer clock source codes
`define NCS_FCLK_TRISTATE          3'h0
`define NCS_FCLK_OSC               3'h1
`define NCS_FCLK_PLL2              3'h2
`define NCS_FCLK_PLL2_DIV2         3'h3
`define NCS_FCLK_SM_2M             3'h4
`define NCS_FCLK_SM_4M             3'h5
`define NCS_FCLK_SM_8M             3'h6
`define NCS_FCLK_SM_16M            3'h7

// Reset values
`define NCS_RST_NETREF_SELECT      8'h00
`define NCS_RST_PROG_CLK_OUTPUTS   8'h00
`define NCS_RST_GENERAL_PURPOSE    8'h00

// Divider half periods, in rising input edges
`define NCS_HALF_OSC_DIV8          3'h4
`define NCS_HALF_DIV2              3'h1

`endif

// ==== core/ncs_sync.v ====
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes every bit is independent; no bus coherency is promised.
`timescale 1ns/1ps

module ncs_sync #(
  parameter W = 22
) (
  input  wire         ref_clk,
  input  wire         rstn,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta;

  // First stage feeds only the second
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // ncs_sync

// ==== core/ncs_top.v ====
// Reference select and bus clock output select, with an Avalon-MM slave.
// Assumes every clock source arrives as an asynchronous level that ref_clk
// oversamples; output clocks are therefore re-timed to ref_clk edges.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ncs_map.vh"

module ncs_top (
  input  wire        ref_clk,
  input  wire        rstn,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Clock sources, all asynchronous
  input  wire        osc_clk,
  input  wire        pll2_clk,
  input  wire [7:0]  local_ref,
  input  wire [3:0]  sm_clk,
  input  wire        int_c8,
  input  wire        int_frame_n,
  input  wire        a_clk_fail,
  input  wire        b_clk_fail,
  // Reference pin and external dejitter loop
  input  wire        netref_in,
  output reg         netref_out,
  output reg         netref_oe,
  output reg         to_dejitter_pin,
  input  wire        from_dejitter_pin,
  output reg         netref_local_out,
  // Framer clock pin
  output reg         framer_clk_out,
  output reg         framer_clk_oe,
  // Bus clock pairs
  input  wire        bus_c8a_in,
  input  wire        bus_c8b_in,
  output reg         ct_c8a_out,
  output reg         ct_c8a_oe,
  output reg         ct_frame_a_n_out,
  output reg         ct_frame_a_n_oe,
  output reg         ct_c8b_out,
  output reg         ct_c8b_oe,
  output reg         ct_frame_b_n_out,
  output reg         ct_frame_b_n_oe,
  output reg         bus_rx_clk_a,
  output reg         bus_rx_clk_b,
  // General purpose bits
  output reg  [7:0]  gp_out
);

  // Registers
  reg  [7:0]  netref_select;
  reg  [7:0]  programmable_clock_outputs;
  reg  [7:0]  general_purpose_reg;

  // Synchronised inputs
  wire [21:0] sync_bus;
  wire        s_osc      = sync_bus[0];
  wire        s_pll2     = sync_bus[1];
  wire [7:0]  s_local    = sync_bus[9:2];
  wire [3:0]  s_sm       = sync_bus[13:10];
  wire        s_c8       = sync_bus[14];
  wire        s_frame_n  = sync_bus[15];
  wire        s_a_fail   = sync_bus[16];
  wire        s_b_fail   = sync_bus[17];
  wire        s_netref   = sync_bus[18];
  wire        s_from_dj  = sync_bus[19];
  wire        s_c8a_in   = sync_bus[20];
  wire        s_c8b_in   = sync_bus[21];

  wire        osc_div8;
  wire        pll2_div2;
  wire        c8_div2;

  // Register fields
  wire        ref_out_enable       = netref_select[`NCS_REF_OUT_ENABLE];
  wire        ref_route_input      = netref_select[`NCS_REF_ROUTE_INPUT];
  wire        dejitter_bypass      = netref_select[`NCS_DEJITTER_BYPASS];
  wire        ref_invert           = netref_select[`NCS_REF_INVERT];
  wire [3:0]  ref_source_sel       =
    netref_select[`NCS_REF_SOURCE_SEL_HI:`NCS_REF_SOURCE_SEL_LO];
  wire [2:0]  framer_clk_source    =
    programmable_clock_outputs[`NCS_FRAMER_CLK_SOURCE_HI:`NCS_FRAMER_CLK_SOURCE_LO];
  wire        bus_clk_input_interp = programmable_clock_outputs[`NCS_BUS_CLK_INPUT_INTERP];
  wire        a_pair_out_enable    = programmable_clock_outputs[`NCS_A_PAIR_OUT_ENABLE];
  wire        b_pair_out_enable    = programmable_clock_outputs[`NCS_B_PAIR_OUT_ENABLE];
  wire        bus_clk_rate_sel     = programmable_clock_outputs[`NCS_BUS_CLK_RATE_SEL];

  // Register decode
  wire [2:0]  reg_index = avs_address[4:2];
  wire        req       = avs_read | avs_write;
  wire        accept    = req & ~avs_waitrequest;
  wire        wr_lane0  = avs_write & accept & avs_byteenable[0];

  reg  [7:0]  next_readdata;
  reg         sel_raw;
  reg         next_framer_clk;
  reg         next_framer_oe;

  ncs_sync #(
    .W (22)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({bus_c8b_in, bus_c8a_in, from_dejitter_pin, netref_in,
                b_clk_fail, a_clk_fail, int_frame_n, int_c8, sm_clk,
                local_ref, pll2_clk, osc_clk}),
    .sync_out (sync_bus)
  );

  // Oscillator over eight for reference code 0000
  ncs_clkgen #(
    .HALF (`NCS_HALF_OSC_DIV8)
  ) u_osc_div8 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_in  (s_osc),
    .clk_out (osc_div8)
  );

  // Second PLL halved for framer code 011
  ncs_clkgen #(
    .HALF (`NCS_HALF_DIV2)
  ) u_pll2_div2 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_in  (s_pll2),
    .clk_out (pll2_div2)
  );

  // Bus clock halved for the 4 MHz output mode
  ncs_clkgen #(
    .HALF (`NCS_HALF_DIV2)
  ) u_c8_div2 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_in  (s_c8),
    .clk_out (c8_div2)
  );

  // Reference source selector; reserved codes give a quiet low
  always @* begin
    case (ref_source_sel)
      `NCS_REF_OSC_DIV8: sel_raw = osc_div8;
      `NCS_REF_OSC:      sel_raw = s_osc;
      default: begin
        if (ref_source_sel[3])
          sel_raw = s_local[ref_source_sel[2:0]];
        else
          sel_raw = 1'b0;
      end
    endcase
  end

  wire sel_out   = sel_raw ^ ref_invert;
  // The dejitter loop is outside; bypass skips it entirely
  wire div_in    = dejitter_bypass ? sel_out : s_from_dj;

  // Reference output path, pin enable and local routing
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      to_dejitter_pin  <= 1'b0;
      netref_out       <= 1'b0;
      netref_oe        <= 1'b0;
      netref_local_out <= 1'b0;
    end else begin
      to_dejitter_pin  <= dejitter_bypass ? 1'b0 : sel_out;
      netref_out       <= div_in;
      // Input routing wins over the enable so two drivers never fight
      netref_oe        <= ref_out_enable & ~ref_route_input;
      netref_local_out <= ref_route_input ? s_netref : div_in;
    end
  end

  // Framer clock selector
  always @* begin
    next_framer_oe = 1'b1;
    case (framer_clk_source)
      `NCS_FCLK_TRISTATE: begin
        next_framer_clk = 1'b0;
        next_framer_oe  = 1'b0;
      end
      `NCS_FCLK_OSC:       next_framer_clk = s_osc;
      `NCS_FCLK_PLL2:      next_framer_clk = s_pll2;
      `NCS_FCLK_PLL2_DIV2: next_framer_clk = pll2_div2;
      `NCS_FCLK_SM_2M:     next_framer_clk = s_sm[0];
      `NCS_FCLK_SM_4M:     next_framer_clk = s_sm[1];
      `NCS_FCLK_SM_8M:     next_framer_clk = s_sm[2];
      `NCS_FCLK_SM_16M:    next_framer_clk = s_sm[3];
      default: begin
        next_framer_clk = 1'b0;
        next_framer_oe  = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      framer_clk_out <= 1'b0;
      framer_clk_oe  <= 1'b0;
    end else begin
      framer_clk_out <= next_framer_clk;
      framer_clk_oe  <= next_framer_oe;
    end
  end

  // Bus clock pairs; one internal source feeds both A and B
  wire bus_clk_tx = bus_clk_rate_sel ? s_c8 : ~c8_div2;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ct_c8a_out       <= 1'b0;
      ct_frame_a_n_out <= 1'b1;
      ct_c8b_out       <= 1'b0;
      ct_frame_b_n_out <= 1'b1;
      ct_c8a_oe        <= 1'b0;
      ct_frame_a_n_oe  <= 1'b0;
      ct_c8b_oe        <= 1'b0;
      ct_frame_b_n_oe  <= 1'b0;
    end else begin
      ct_c8a_out       <= bus_clk_tx;
      ct_frame_a_n_out <= s_frame_n;
      ct_c8b_out       <= bus_clk_tx;
      ct_frame_b_n_out <= s_frame_n;
      // Failure drops the drivers three ref_clk edges later, without touching the enable bit
      ct_c8a_oe        <= a_pair_out_enable & ~s_a_fail;
      ct_frame_a_n_oe  <= a_pair_out_enable & ~s_a_fail;
      ct_c8b_oe        <= b_pair_out_enable & ~s_b_fail;
      ct_frame_b_n_oe  <= b_pair_out_enable & ~s_b_fail;
    end
  end

  // Received bus clocks as seen by the clock selector
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rx_clk_a <= 1'b0;
      bus_rx_clk_b <= 1'b0;
    end else begin
      bus_rx_clk_a <= bus_clk_input_interp ? s_c8a_in : ~s_c8a_in;
      bus_rx_clk_b <= bus_clk_input_interp ? s_c8b_in : ~s_c8b_in;
    end
  end

  // General purpose pins; top two bits are free only while routing in
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gp_out <= 8'h00;
    end else begin
      gp_out[5:0] <= general_purpose_reg[5:0];
      gp_out[7:6] <= ref_route_input ? general_purpose_reg[7:6] : 2'h0;
    end
  end

  // Register writes on the accepting edge, low byte lane only
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      netref_select              <= `NCS_RST_NETREF_SELECT;
      programmable_clock_outputs <= `NCS_RST_PROG_CLK_OUTPUTS;
      general_purpose_reg        <= `NCS_RST_GENERAL_PURPOSE;
    end else if (wr_lane0) begin
      case (reg_index)
        `NCS_IDX_NETREF_SELECT:    netref_select              <= avs_writedata[7:0];
        `NCS_IDX_PROG_CLK_OUTPUTS: programmable_clock_outputs <= avs_writedata[7:0];
        `NCS_IDX_GENERAL_PURPOSE: begin
          general_purpose_reg[5:0] <= avs_writedata[5:0];
          // Bits 6 and 7 accept writes only while they are usable
          if (ref_route_input)
            general_purpose_reg[7:6] <= avs_writedata[7:6];
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (reg_index)
      `NCS_IDX_NETREF_SELECT:    next_readdata = netref_select;
      `NCS_IDX_PROG_CLK_OUTPUTS: next_readdata = programmable_clock_outputs;
      `NCS_IDX_STATUS:           next_readdata = {2'h0, ref_route_input, s_netref,
                                                  ct_c8b_oe, ct_c8a_oe,
                                                  s_b_fail, s_a_fail};
      `NCS_IDX_GENERAL_PURPOSE:  next_readdata = general_purpose_reg;
      default:                   next_readdata = 8'h00;
    endcase
  end

  // One wait state: waitrequest drops the cycle after a request appears
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      if (req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h00_0000, next_readdata};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule // ncs_top

// ==== testbench/ncs_peer.sv ====
// Far-side peer: shares the reference line and drives the A and B bus clocks.
// Assumes the device enable is high only while the device drives the line.
`timescale 1ns/1ps
module ncs_peer (
  input  wire  netref_out,
  input  wire  netref_oe,
  input  wire  peer_ref,
  output logic netref_in,
  output logic bus_c8a_in,
  output logic bus_c8b_in
);
  // Line level: the device when it drives, else the peer's own level
  assign netref_in = netref_oe ? netref_out : peer_ref;
  // Bus clock runs free, phase unrelated to ref_clk
  initial begin
    bus_c8a_in = 1'b0;
    #137;
    forever #400 bus_c8a_in = ~bus_c8a_in;
  end
  // Opposite phase on B so both readings see each level
  assign bus_c8b_in = ~bus_c8a_in;
endmodule // ncs_peer

// ==== testbench/ncs_top_monitor.sv ====
// Port checker of the reference and bus clock output select block.
// Assumes writes land on the accepting edge and pins lag inputs by 3 edges.
`timescale 1ns/1ps
`include "ncs_map.vh"
module ncs_top_monitor (
  input wire        ref_clk,
  input wire        rstn,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        int_c8,
  input wire        int_frame_n,
  input wire        a_clk_fail,
  input wire        b_clk_fail,
  input wire        bus_c8a_in,
  input wire        bus_c8b_in,
  input wire        netref_oe,
  input wire        to_dejitter_pin,
  input wire        framer_clk_oe,
  input wire        ct_c8a_out,
  input wire        ct_c8a_oe,
  input wire        ct_frame_a_n_out,
  input wire        ct_frame_a_n_oe,
  input wire        ct_c8b_out,
  input wire        ct_c8b_oe,
  input wire        ct_frame_b_n_out,
  input wire        ct_frame_b_n_oe,
  input wire        bus_rx_clk_a,
  input wire        bus_rx_clk_b,
  input wire [7:0]  gp_out
);
  logic [3:0] quiet;
  logic [7:0] sh_n;
  logic [7:0] sh_p;
  wire        acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire        q   = quiet > 4'h4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Shadow registers; quiet keeps checks off while settings settle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      quiet <= 4'h0;
      sh_n  <= 8'h00;
      sh_p  <= 8'h00;
    end else begin
      quiet <= acc ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      if (acc && avs_address[4:2] == `NCS_IDX_NETREF_SELECT)
        sh_n <= avs_writedata[7:0];
      if (acc && avs_address[4:2] == `NCS_IDX_PROG_CLK_OUTPUTS)
        sh_p <= avs_writedata[7:0];
    end
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_access;
    s_req |=> s_ack;
  endproperty
  property p_ref_oe;
    q |-> netref_oe == (sh_n[7] && !sh_n[6]);
  endproperty
  property p_bypass;
    q && sh_n[5] |-> !to_dejitter_pin;
  endproperty
  property p_gp_lock;
    q && !sh_n[6] |-> gp_out[7:6] == 2'b00;
  endproperty
  property p_fclk_oe;
    q |-> framer_clk_oe == (sh_p[7:5] != 3'h0);
  endproperty
  property p_a_pair;
    q |-> ct_c8a_oe == (sh_p[3] && !$past(a_clk_fail, 3)) && ct_frame_a_n_oe == ct_c8a_oe;
  endproperty
  property p_b_pair;
    q |-> ct_c8b_oe == (sh_p[2] && !$past(b_clk_fail, 3)) && ct_frame_b_n_oe == ct_c8b_oe;
  endproperty
  property p_rate8;
    q && sh_p[1] |-> ct_c8a_out == $past(int_c8, 3);
  endproperty
  property p_both;
    q |-> ct_c8b_out == ct_c8a_out && ct_frame_a_n_out == $past(int_frame_n, 3)
      && ct_frame_b_n_out == ct_frame_a_n_out;
  endproperty
  property p_rx_a;
    q |-> bus_rx_clk_a == ($past(bus_c8a_in, 3) ^ !sh_p[4]);
  endproperty
  property p_rx_b;
    q |-> bus_rx_clk_b == ($past(bus_c8b_in, 3) ^ !sh_p[4]);
  endproperty
  a_access: assert property (p_access) else $error("bus wait state wrong");
  a_ref_oe: assert property (p_ref_oe) else $error("ref enable wrong");
  a_bypass: assert property (p_bypass) else $error("dejitter pin not idle");
  a_gp_lock: assert property (p_gp_lock) else $error("gp high bits free");
  a_fclk_oe: assert property (p_fclk_oe) else $error("framer enable wrong");
  a_a_pair: assert property (p_a_pair) else $error("A pair enable wrong");
  a_b_pair: assert property (p_b_pair) else $error("B pair enable wrong");
  a_rate8: assert property (p_rate8) else $error("8 MHz clock wrong");
  a_both: assert property (p_both) else $error("pairs differ");
  a_rx_a: assert property (p_rx_a) else $error("A input reading wrong");
  a_rx_b: assert property (p_rx_b) else $error("B input reading wrong");
endmodule // ncs_top_monitor

bind ncs_top ncs_top_monitor u_ncs_top_monitor (.*);

// ==== testbench/ncs_top_tb.sv ====
// Bench of the reference and bus clock output select block.
// Assumes ncs_top with its bound checker and the ncs_peer model.
`timescale 1ns/1ps
module ncs_top_tb;
  logic        ref_clk = 1'b0, rstn = 1'b0, chk = 1'b0, s, dv;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
  logic [3:0]  avs_byteenable = 4'hF, sm_clk = 4'h0, c;
  logic [7:0]  local_ref = 8'h00, gp_out, d, e;
  logic        osc_clk = 1'b0, pll2_clk = 1'b0, int_c8 = 1'b0, int_frame_n = 1'b1;
  logic        a_clk_fail = 1'b0, b_clk_fail = 1'b0, from_dejitter_pin = 1'b0;
  logic        peer_ref = 1'b0, netref_in, bus_c8a_in, bus_c8b_in;
  logic        netref_out, netref_oe, to_dejitter_pin, netref_local_out;
  logic        framer_clk_out, framer_clk_oe, bus_rx_clk_a, bus_rx_clk_b;
  logic        ct_c8a_out, ct_c8a_oe, ct_frame_a_n_out, ct_frame_a_n_oe;
  logic        ct_c8b_out, ct_c8b_oe, ct_frame_b_n_out, ct_frame_b_n_oe;
  logic [43:0] pin_q[$], pn;
  logic [31:0] rd_q[$];
  int          failures = 0, cmp_count = 0, i;
  wire  [21:0] pv = {netref_out, netref_oe, to_dejitter_pin, netref_local_out,
    framer_clk_out, framer_clk_oe, ct_c8a_out, ct_c8a_oe, ct_frame_a_n_out,
    ct_frame_a_n_oe, ct_c8b_out, ct_c8b_oe, ct_frame_b_n_out, ct_frame_b_n_oe, gp_out};

  ncs_top u_ncs_top (.*);
  ncs_peer u_ncs_peer (.*);

  // 10 MHz clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  // One access; held until waitrequest is seen low, bounded
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] wd, input logic be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= {24'h0, wd};
    avs_byteenable <= {3'h7, be};
    avs_write      <= w;
    avs_read       <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      print_verdict;
    end else begin
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      // One idle edge so a following call never reassigns in this step
      @(posedge ref_clk);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] ex);
    rd_q.push_back({24'h0, ex});
    bus(1'b0, a, 8'h00, 1'b1);
  endtask

  // Eight cycles cover the three to four edge input-to-pin lag
  task automatic pins(input logic [21:0] ex, input logic [21:0] m);
    repeat (8) @(posedge ref_clk);
    pin_q.push_back({m, ex});
    chk <= 1'b1;
    @(posedge ref_clk);
    chk <= 1'b0;
  endtask

  // Watcher: oldest note against what the design shows now
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      cmp(rd_q.pop_front(), avs_readdata);
    if (chk) begin
      pn = pin_q.pop_front();
      cmp({10'h0, pn[21:0] & pn[43:22]}, {10'h0, pv & pn[43:22]});
    end
  end

  initial begin
    r = $urandom(84670);
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(5'h04, 8'h00);
    rd(5'h08, 8'h00);
    rd(5'h10, 8'h00);
    pins(22'h0, 22'h1155FF);
    $display("T1 reset state done");
    // Legal codes only; reserved codes and frame width bit stay clear
    repeat (8) begin
      c = 4'($urandom_range(9, 0));
      d = 8'($urandom);
      d[3:0] = (c > 4'h1) ? c + 4'h6 : c;
      e = 8'($urandom) & 8'hFE;
      bus(1'b1, 5'h04, d, 1'b1);
      rd(5'h04, d);
      bus(1'b1, 5'h08, e, 1'b1);
      rd(5'h08, e);
    end
    bus(1'b1, 5'h08, 8'h5A, 1'b0);
    rd(5'h08, e);
    bus(1'b1, 5'h1C, 8'hFF, 1'b1);
    rd(5'h1C, 8'h00);
    $display("T2 register access done");
    // Every legal source code but 0000, with invert and bypass both ways
    for (i = 0; i < 36; i++) begin
      r = $urandom;
      local_ref <= r[7:0];
      osc_clk <= r[8];
      from_dejitter_pin <= r[9];
      c = (i[5:2] == 4'h8) ? 4'h1 : {1'b1, i[4:2]};
      s = ((i[5:2] == 4'h8) ? r[8] : r[i[4:2]]) ^ i[0];
      dv = i[1] ? s : r[9];
      bus(1'b1, 5'h04, {2'b10, i[1], i[0], c}, 1'b1);
      pins({dv, 1'b1, s & !i[1], dv, 18'h0}, 22'h3C0000);
    end
    $display("T3 reference path done");
    for (i = 0; i < 4; i++) begin
      r = $urandom;
      peer_ref <= r[0];
      bus(1'b1, 5'h04, {i[0], 7'h41}, 1'b1);
      bus(1'b1, 5'h10, 8'hC5, 1'b1);
      pins({3'b000, r[0], 10'h0, 8'hC5}, 22'h1400FF);
    end
    bus(1'b1, 5'h04, 8'h01, 1'b1);
    bus(1'b1, 5'h10, 8'hFA, 1'b1);
    pins({14'h0, 8'h3A}, 22'h1000FF);
    $display("T4 reference input done");
    for (i = 0; i < 16; i++) begin
      r = $urandom;
      osc_clk <= r[0];
      pll2_clk <= r[1];
      sm_clk <= r[5:2];
      bus(1'b1, 5'h08, {i[2:0], 5'h00}, 1'b1);
      s = (i[2:0] == 3'h1) ? r[0] : (i[2:0] == 3'h2) ? r[1] : r[i[1:0] + 2];
      pins({4'h0, s, i[2:0] != 3'h0, 16'h0},
           (i[2:0] == 3'h0 || i[2:0] == 3'h3) ? 22'h010000 : 22'h030000);
    end
    $display("T5 framer clock done");
    // Enables against failures, 8 MHz mode on static bus levels
    for (i = 0; i < 16; i++) begin
      r = $urandom;
      a_clk_fail <= i[2];
      b_clk_fail <= i[3];
      int_c8 <= r[0];
      int_frame_n <= r[1];
      bus(1'b1, 5'h08, {3'h0, r[2], i[0], i[1], 2'b10}, 1'b1);
      pins({6'h0, r[0], i[0] & !i[2], r[1], i[0] & !i[2], r[0], i[1] & !i[3], r[1],
            i[1] & !i[3], 8'h0}, 22'h00FF00);
    end
    $display("T6 bus clock pairs done");
    // Mid-run reset; dividers then counted from their reset phase
    int_c8   <= 1'b0;
    osc_clk  <= 1'b0;
    pll2_clk <= 1'b0;
    rstn     <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(5'h04, 8'h00);
    rd(5'h08, 8'h00);
    bus(1'b1, 5'h04, 8'hA0, 1'b1);
    bus(1'b1, 5'h08, 8'h60, 1'b1);
    for (i = 1; i < 9; i++) begin
      int_c8   <= 1'b1;
      osc_clk  <= 1'b1;
      pll2_clk <= 1'b1;
      pins({i[2], 2'b10, i[2], i[0], 1'b1, !i[0], 3'h0, !i[0], 11'h0},
           22'h3F8800);
      int_c8   <= 1'b0;
      osc_clk  <= 1'b0;
      pll2_clk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    $display("T7 mid-run reset and dividers done");
    print_verdict;
  end
endmodule // ncs_top_tb
